// File: hw/mstr_params.svh
/*
  Constants for the motion status and sensor time register slice: register
  offsets, flag positions, reset values and timing figures.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef MSTR_PARAMS_SVH
`define MSTR_PARAMS_SVH

// register offsets on the serial register port
`define MSTR_ADDR_ACC_Z_HI 8'h17
`define MSTR_ADDR_TIME0 8'h18
`define MSTR_ADDR_TIME1 8'h19
`define MSTR_ADDR_TIME2 8'h1A
`define MSTR_ADDR_POWER_EVENT 8'h1B
`define MSTR_ADDR_FEATURE_IRQ 8'h1C
`define MSTR_ADDR_DATA_IRQ 8'h1D
`define MSTR_ADDR_PEDO0 8'h1E
`define MSTR_ADDR_PEDO1 8'h1F
`define MSTR_ADDR_PEDO2 8'h20
`define MSTR_ADDR_PEDO3 8'h21

// power event register
`define MSTR_BIT_POR_DETECTED 0

// feature interrupt register (bits 0 and 4 reserved)
`define MSTR_BIT_STEP 1
`define MSTR_BIT_ACTIVITY 2
`define MSTR_BIT_WRIST_TILT 3
`define MSTR_BIT_WAKEUP 5
`define MSTR_BIT_ANY_NO_MOTION 6
`define MSTR_BIT_ERROR 7

// data interrupt register (bits 2, 3, 4, 6 reserved)
`define MSTR_BIT_FIFO_FULL 0
`define MSTR_BIT_FIFO_WM 1
`define MSTR_BIT_AUX_DRDY 5
`define MSTR_BIT_ACC_DRDY 7

// reset values
`define MSTR_RST_POWER_EVENT 8'h01
`define MSTR_RST_FEATURE_IRQ 8'h00
`define MSTR_RST_DATA_IRQ 8'h00
`define MSTR_RST_DATA 8'h00

// timing: clock rate and sensor time resolution as printed
`define MSTR_CLK_MHZ 25
`define MSTR_TIME_TICK_US 39.0625
`define MSTR_TIME_BYTE1_MS 10
`define MSTR_TIME_BYTE2_S 2.56
`define MSTR_TIME_WIDTH 24

`endif

// File: hw/mstr_pkg.sv
/*
  Types shared by the motion status and sensor time register slice.
  Assumes mstr_params.svh is on the include path.
*/
`include "mstr_params.svh"

package mstr_pkg;

  typedef logic [7:0] mstr_byte_t;
  typedef logic [`MSTR_TIME_WIDTH-1:0] mstr_time_t;
  typedef logic [31:0] mstr_steps_t;

endpackage

// File: hw/mstr_sensor_time.sv
/*
  Free running sensor time counter. A fractional accumulator in picoseconds
  produces the tick, so the average tick period is exact even though it is
  not a whole number of core clock cycles.
  Assumes a single clock, a clock enable and a synchronous soft clear.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mstr_params.svh"

module mstr_sensor_time #(
  parameter int TIME_WIDTH = `MSTR_TIME_WIDTH,
  parameter int CLK_MHZ = `MSTR_CLK_MHZ
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic soft_clear,
  output logic [TIME_WIDTH-1:0] time_count
);

  localparam longint CLK_PS = 64'd1000000 / 64'(CLK_MHZ);
  localparam longint TICK_PS = longint'(`MSTR_TIME_TICK_US * 1000000.0);
  // byte 1 step and byte 2 step follow from the bit weights of the counter
  localparam longint BYTE1_PS = longint'(`MSTR_TIME_BYTE1_MS * 1000000000.0);
  localparam longint BYTE2_PS = longint'(`MSTR_TIME_BYTE2_S * 1000000000000.0);

  generate
    if (TIME_WIDTH != 24 || CLK_PS < 1 || CLK_PS >= TICK_PS) begin : g_bad_cfg
      $error("mstr_sensor_time: unsupported width or clock rate");
    end
    if (TICK_PS * 256 != BYTE1_PS || TICK_PS * 65536 != BYTE2_PS) begin : g_bad_weights
      $error("mstr_sensor_time: tick does not match byte weights");
    end
  endgenerate

  localparam logic [31:0] CLK_PS_W = 32'(CLK_PS);
  localparam logic [31:0] TICK_PS_W = 32'(TICK_PS);

  logic [31:0] phase_acc;
  logic [31:0] next_phase_acc;
  logic tick;

  always_comb begin
    next_phase_acc = phase_acc + CLK_PS_W;
    tick = 1'b0;
    if (next_phase_acc >= TICK_PS_W) begin
      next_phase_acc = next_phase_acc - TICK_PS_W;
      tick = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_acc <= 32'h0000_0000;
    end else if (ce) begin
      if (soft_clear) begin
        phase_acc <= 32'h0000_0000;
      end else begin
        phase_acc <= next_phase_acc;
      end
    end
  end

  // lsb weighs one tick, bits 15:8 weigh 256 ticks, bits 23:16 weigh 65536
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      time_count <= '0;
    end else if (ce) begin
      if (soft_clear) begin
        time_count <= '0;
      end else if (tick) begin
        time_count <= time_count + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// File: hw/mstr_status_regs.sv
/*
  Read-only status and data register slice of a motion sensor: Z-axis high
  byte, 24-bit sensor time, power event flag, two clear-on-read interrupt
  status registers and the 32-bit step count.
  Assumes the serial interface front end presents one byte access per
  reg_rd or reg_wr pulse, and that the feature engines deliver one-cycle
  event pulses and the current step count, all synchronous to core_clk.
*/
// Operation
// - a 24-bit sensor time counter ticks every 39.0625 us and is read through three byte registers.
// - the second time byte holds counter bits 15 to 8, one count of it being 10 ms.
// - the third time byte holds counter bits 23 to 16, one count of it being 2.56 s.
// - the power event bit 0 is set after power up or soft reset and cleared when its register is read.
// - reading the feature interrupt register clears all its flags.
// - feature bit 1 sets on step watermark, or on each detected step in step detector mode.
// - feature bits are activity 2, wrist tilt 3, wake-up 5, any/no-motion 6, error 7; bits 0 and 4 read zero.
// - reading the data interrupt register clears all its flags.
// - data bits are FIFO full 0, FIFO watermark 1, aux ready 5, accel ready 7; other bits read zero.
// - step count bytes rise with address, least significant byte at the lowest.
// - the most significant step count byte sits in the fourth step register after byte 2.
`timescale 1ns/1ns
`default_nettype none
`include "mstr_params.svh"

module mstr_status_regs (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic soft_reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output mstr_pkg::mstr_byte_t reg_rdata,
  output logic reg_rvalid,
  input wire logic [7:0] accel_z_high,
  input wire logic [31:0] step_count,
  input wire logic step_detector_mode,
  input wire logic step_watermark_hit,
  input wire logic step_detected,
  input wire logic activity_changed,
  input wire logic wrist_tilt_seen,
  input wire logic wakeup_seen,
  input wire logic any_no_motion_seen,
  input wire logic error_seen,
  input wire logic fifo_full_seen,
  input wire logic fifo_watermark_seen,
  input wire logic aux_data_ready,
  input wire logic accel_data_ready,
  output mstr_pkg::mstr_time_t sensor_time
);

  mstr_pkg::mstr_time_t time_count;
  mstr_pkg::mstr_byte_t power_event_flags;
  mstr_pkg::mstr_byte_t feature_irq_flags;
  mstr_pkg::mstr_byte_t data_irq_flags;
  mstr_pkg::mstr_byte_t next_power_event_flags;
  mstr_pkg::mstr_byte_t next_feature_irq_flags;
  mstr_pkg::mstr_byte_t next_data_irq_flags;
  mstr_pkg::mstr_byte_t feature_set;
  mstr_pkg::mstr_byte_t data_set;
  mstr_pkg::mstr_byte_t read_value;
  logic [15:0] time_shadow;
  logic [23:0] steps_shadow;
  logic rd_event;
  logic rd_feature;
  logic rd_data;
  logic rd_power;
  logic rd_time_low;
  logic rd_steps_low;

  mstr_sensor_time #(
    .TIME_WIDTH(`MSTR_TIME_WIDTH),
    .CLK_MHZ(`MSTR_CLK_MHZ)
  ) u_time (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .ce(ce),
    .soft_clear(soft_reset),
    .time_count(time_count)
  );

  // writes never reach any storage; reg_wdata is dropped and reg_wr only blocks a read in the same cycle
  assign rd_event = reg_rd && !reg_wr;
  assign rd_power = rd_event && (reg_addr == `MSTR_ADDR_POWER_EVENT);
  assign rd_feature = rd_event && (reg_addr == `MSTR_ADDR_FEATURE_IRQ);
  assign rd_data = rd_event && (reg_addr == `MSTR_ADDR_DATA_IRQ);
  assign rd_time_low = rd_event && (reg_addr == `MSTR_ADDR_TIME0);
  assign rd_steps_low = rd_event && (reg_addr == `MSTR_ADDR_PEDO0);

  always_comb begin
    feature_set = 8'h00;
    feature_set[`MSTR_BIT_STEP] = step_watermark_hit || (step_detector_mode && step_detected);
    feature_set[`MSTR_BIT_ACTIVITY] = activity_changed;
    feature_set[`MSTR_BIT_WRIST_TILT] = wrist_tilt_seen;
    feature_set[`MSTR_BIT_WAKEUP] = wakeup_seen;
    feature_set[`MSTR_BIT_ANY_NO_MOTION] = any_no_motion_seen;
    feature_set[`MSTR_BIT_ERROR] = error_seen;
  end

  always_comb begin
    data_set = 8'h00;
    data_set[`MSTR_BIT_FIFO_FULL] = fifo_full_seen;
    data_set[`MSTR_BIT_FIFO_WM] = fifo_watermark_seen;
    data_set[`MSTR_BIT_AUX_DRDY] = aux_data_ready;
    data_set[`MSTR_BIT_ACC_DRDY] = accel_data_ready;
  end

  // an event landing in the read cycle survives the clear and shows next read
  always_comb begin
    next_power_event_flags = rd_power ? 8'h00 : power_event_flags;
    next_feature_irq_flags = (rd_feature ? 8'h00 : feature_irq_flags) | feature_set;
    next_data_irq_flags = (rd_data ? 8'h00 : data_irq_flags) | data_set;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      power_event_flags <= `MSTR_RST_POWER_EVENT;
    end else if (ce) begin
      if (soft_reset) begin
        power_event_flags <= `MSTR_RST_POWER_EVENT;
      end else begin
        power_event_flags <= next_power_event_flags;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      feature_irq_flags <= `MSTR_RST_FEATURE_IRQ;
    end else if (ce) begin
      if (soft_reset) begin
        feature_irq_flags <= `MSTR_RST_FEATURE_IRQ;
      end else begin
        feature_irq_flags <= next_feature_irq_flags;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_irq_flags <= `MSTR_RST_DATA_IRQ;
    end else if (ce) begin
      if (soft_reset) begin
        data_irq_flags <= `MSTR_RST_DATA_IRQ;
      end else begin
        data_irq_flags <= next_data_irq_flags;
      end
    end
  end

  // reading the low byte freezes the upper bytes, so a burst that starts at
  // the low byte sees one coherent sample; a host that starts higher up gets
  // whatever the last low-byte read froze
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      time_shadow <= 16'h0000;
    end else if (ce) begin
      if (soft_reset) begin
        time_shadow <= 16'h0000;
      end else if (rd_time_low) begin
        time_shadow <= time_count[23:8];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      steps_shadow <= 24'h00_0000;
    end else if (ce) begin
      if (soft_reset) begin
        steps_shadow <= 24'h00_0000;
      end else if (rd_steps_low) begin
        steps_shadow <= step_count[31:8];
      end
    end
  end

  always_comb begin
    case (reg_addr)
      `MSTR_ADDR_ACC_Z_HI: read_value = accel_z_high;
      `MSTR_ADDR_TIME0: read_value = time_count[7:0];
      `MSTR_ADDR_TIME1: read_value = time_shadow[7:0];
      `MSTR_ADDR_TIME2: read_value = time_shadow[15:8];
      `MSTR_ADDR_POWER_EVENT: read_value = power_event_flags;
      `MSTR_ADDR_FEATURE_IRQ: read_value = feature_irq_flags;
      `MSTR_ADDR_DATA_IRQ: read_value = data_irq_flags;
      `MSTR_ADDR_PEDO0: read_value = step_count[7:0];
      `MSTR_ADDR_PEDO1: read_value = steps_shadow[7:0];
      `MSTR_ADDR_PEDO2: read_value = steps_shadow[15:8];
      `MSTR_ADDR_PEDO3: read_value = steps_shadow[23:16];
      // addresses outside this slice answer zero
      default: read_value = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= rd_event;
    end
  end

  // read data hold until the next taken read so a slow front end can fetch them late
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= `MSTR_RST_DATA;
    end else if (ce && rd_event) begin
      reg_rdata <= read_value;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sensor_time <= '0;
    end else if (ce) begin
      sensor_time <= time_count;
    end
  end

endmodule

`default_nettype wire

// File: tb/mstr_host.sv
/* Host model on the register port: single byte reads and writes.
   Assumes the caller judges the answer flag of each read. */
`timescale 1ns/1ns
`default_nettype none
module mstr_host (
  input wire logic core_clk,
  input wire mstr_pkg::mstr_byte_t reg_rdata,
  input wire logic reg_rvalid,
  output logic [7:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_addr = 8'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic rd(input logic [7:0] a, output mstr_pkg::mstr_byte_t d, output logic ok);
    int n;
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    // idle address wanders so a stale one is never trusted
    reg_addr = ~a;
    for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) @(negedge core_clk);
    ok = (reg_rvalid === 1'b1);
    d = reg_rdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_wdata = ~v;
  endtask
endmodule
`default_nettype wire

// File: tb/mstr_status_regs_properties.sv
/* Port checker for mstr_status_regs, bound below.
   Assumes ce stays high around reads and soft_reset is a short pulse. */
`timescale 1ns/1ns
`default_nettype none
module mstr_status_regs_props (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic soft_reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire mstr_pkg::mstr_byte_t reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [31:0] step_count,
  input wire mstr_pkg::mstr_time_t sensor_time
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic [10:0] gap;
  // enabled edges since the time last moved; pauses with ce like the timer
  // single clock event so the sampled-value clock is unambiguous
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      gap <= 11'h000;
    end else if (soft_reset || $changed(sensor_time)) begin
      gap <= 11'h000;
    end else if (ce) begin
      gap <= gap + 11'h001;
    end
  end
  property p_answer; ce && reg_rd && !reg_wr |=> reg_rvalid; endproperty
  a_answer: assert property (p_answer) else $error("read not answered");
  property p_cause; reg_rvalid |-> $past(ce && reg_rd && !reg_wr); endproperty
  a_cause: assert property (p_cause) else $error("answer without read");
  property p_hold; !reg_rvalid |-> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_step0; reg_rvalid && $past(reg_addr) == 8'h1E |-> reg_rdata == $past(step_count[7:0]); endproperty
  a_step0: assert property (p_step0) else $error("step low byte wrong");
  property p_unmapped; reg_rvalid && !($past(reg_addr) inside {[8'h17:8'h21]}) |-> reg_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
  property p_reserved;
    reg_rvalid && $past(reg_addr) inside {8'h1B, 8'h1C, 8'h1D} |-> (reg_rdata &
      (($past(reg_addr) == 8'h1B) ? 8'hFE : ($past(reg_addr) == 8'h1C) ? 8'h11 : 8'h5C)) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");
  property p_time_step; $changed(sensor_time) |-> sensor_time == $past(sensor_time) + 1'b1 || sensor_time == '0; endproperty
  a_time_step: assert property (p_time_step) else $error("time jumped");
  property p_tick_min; $changed(sensor_time) && sensor_time != '0 |-> gap >= 11'd974 && gap <= 11'd978; endproperty
  a_tick_min: assert property (p_tick_min) else $error("tick period off");
  property p_tick_max; gap <= 11'd980; endproperty
  a_tick_max: assert property (p_tick_max) else $error("tick missing");
endmodule
bind mstr_status_regs mstr_status_regs_props props_i (
  .core_clk(core_clk),
  .rst_b(rst_b),
  .ce(ce),
  .soft_reset(soft_reset),
  .reg_addr(reg_addr),
  .reg_rd(reg_rd),
  .reg_wr(reg_wr),
  .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid),
  .step_count(step_count),
  .sensor_time(sensor_time)
);
`default_nettype wire

// File: tb/tb.sv
/* Self-checking bench for mstr_status_regs driven by the host model.
   Assumes a 25 MHz core clock; stimulus changes on falling edges. */
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic soft_reset = 1'b0;
  logic step_detector_mode = 1'b0;
  logic step_detected = 1'b0;
  logic [9:0] ev = 10'h000;
  logic [7:0] accel_z_high = 8'h00;
  logic [31:0] step_count = 32'h00000000;
  logic [7:0] reg_addr, reg_wdata;
  logic reg_rd, reg_wr, reg_rvalid;
  mstr_pkg::mstr_byte_t reg_rdata, d;
  mstr_pkg::mstr_time_t sensor_time;
  int fail_count = 0;
  int cmp_count = 0;
  always #20 core_clk = ~core_clk;
  mstr_host mstr_host_i (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata));
  mstr_status_regs mstr_status_regs_i (.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .soft_reset(soft_reset),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .accel_z_high(accel_z_high), .step_count(step_count),
    .step_detector_mode(step_detector_mode), .step_detected(step_detected), .sensor_time(sensor_time),
    .step_watermark_hit(ev[0]), .activity_changed(ev[1]),
    .wrist_tilt_seen(ev[2]), .wakeup_seen(ev[3]), .any_no_motion_seen(ev[4]), .error_seen(ev[5]),
    .fifo_full_seen(ev[6]), .fifo_watermark_seen(ev[7]), .aux_data_ready(ev[8]), .accel_data_ready(ev[9]));
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic rc(input logic [7:0] a, input mstr_pkg::mstr_byte_t exp);
    logic ok;
    mstr_host_i.rd(a, d, ok);
    cmp_count++;
    if (!ok) begin
      fail_count++;
      $display("BAD t=%0t addr %h read not answered", $time, a);
      summarize();
    end else if (d !== exp) begin
      fail_count++;
      $display("BAD t=%0t addr %h read %h expected %h", $time, a, d, exp);
    end
  endtask
  task automatic cs(input mstr_pkg::mstr_time_t exp);
    cmp_count++;
    if (sensor_time !== exp) begin
      fail_count++;
      $display("BAD t=%0t sensor time %h expected %h", $time, sensor_time, exp);
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic t_reset();
    rc(8'h1B, 8'h01);
    rc(8'h1B, 8'h00);
    rc(8'h1C, 8'h00);
    rc(8'h1D, 8'h00);
    rc(8'h18, 8'h00);
    cs(24'h00_0000);
    $display("reset values done");
  endtask
  task automatic t_flags();
    int pos[10] = '{1, 2, 3, 5, 6, 7, 0, 1, 5, 7};
    for (int i = 0; i < 12; i++) begin
      cyc(1);
      step_detector_mode = (i == 11);
      if (i < 10) ev = 10'h001 << i;
      else step_detected = 1'b1;
      cyc(1);
      ev = 10'h000;
      step_detected = 1'b0;
      // step detections count only in detector mode
      rc(i < 6 || i > 9 ? 8'h1C : 8'h1D, i < 10 ? 8'h01 << pos[i] : (i == 11 ? 8'h02 : 8'h00));
      rc(i < 6 || i > 9 ? 8'h1C : 8'h1D, 8'h00);
    end
    $display("flags done");
  endtask
  task automatic t_steps();
    step_count = 32'h12345678;
    rc(8'h1E, 8'h78);
    step_count = 32'hAABBCCDD;
    rc(8'h1F, 8'h56);
    rc(8'h20, 8'h34);
    rc(8'h21, 8'h12);
    rc(8'h1E, 8'hDD);
    rc(8'h21, 8'hAA);
    $display("steps done");
  endtask
  task automatic t_misc();
    accel_z_high = 8'hA5;
    rc(8'h17, 8'hA5);
    mstr_host_i.wr(8'h1C, 8'hFF);
    rc(8'h1C, 8'h00);
    mstr_host_i.wr(8'h1B, 8'hFF);
    rc(8'h1B, 8'h00);
    rc(8'h16, 8'h00);
    rc(8'h30, 8'h00);
    $display("writes and unmapped done");
  endtask
  task automatic t_time();
    longint t;
    t = 64'd60000 * 64'd40000 / 64'd39062500;
    cyc(1);
    soft_reset = 1'b1;
    cyc(1);
    soft_reset = 1'b0;
    cyc(30000);
    ce = 1'b0;
    cyc(3000);
    ce = 1'b1;
    cyc(30000);
    rc(8'h18, t[7:0]);
    rc(8'h19, t[15:8]);
    rc(8'h1A, t[23:16]);
    cs(t[23:0]);
    rc(8'h1B, 8'h01);
    $display("sensor time done");
  endtask
  // an event in the very cycle of the clearing read must survive to the next read
  task automatic t_collide();
    fork
      rc(8'h1C, 8'h00);
      begin
        @(negedge core_clk);
        ev = 10'h002;
        @(negedge core_clk);
        ev = 10'h000;
      end
    join
    rc(8'h1C, 8'h04);
    rc(8'h1C, 8'h00);
    $display("set over clear done");
  endtask
  task automatic t_rerun();
    ev = 10'h002;
    cyc(1);
    ev = 10'h000;
    rst_b = 1'b0;
    cyc(2);
    rst_b = 1'b1;
    t_reset();
    $display("mid-run reset done");
  endtask
  initial begin
    cyc(12);
    rst_b = 1'b1;
    t_reset();
    t_flags();
    t_steps();
    t_misc();
    t_collide();
    t_rerun();
    t_time();
    summarize();
  end
endmodule
`default_nettype wire
